// File: rtl/perfmon_freeze_overflow_status.sv
// counter freeze/overflow status registers and irq upper address register
`timescale 1ns/1ps
`include "perfmon_params.svh"

// Behaviour
// RULE1 - with extended interrupt mode the upper irq address is a 32-bit read-write register reset to zero.
// RULE2 - without extended interrupt mode the upper irq address reads zero and ignores writes.
// RULE3 - without monitoring support the upper address reads zero and the status registers are absent.
// RULE4 - freeze state is a read-only 64-bit vector per group of 64 counters at freeze base plus eight per index.
// RULE5 - a freeze bit at zero means the counter is not frozen, whether disabled or counting.
// RULE6 - a freeze bit at one means the counter is frozen and stays so until software unfreezes it.
// RULE7 - freeze bits change only through commands of the enhanced command interface.
// RULE8 - a successful disable-counter command clears the freeze bit of that counter.
// RULE9 - overflow state is a 64-bit vector per group of 64 counters at overflow base plus eight per index.
// RULE10 - a counter overflow sets its overflow bit, and zero means no overflow since the last clear.
// RULE11 - writing one to an overflow bit clears it.
// RULE12 - just enough status registers exist to give every reported counter one bit.
// RULE13 - writing zero leaves an overflow bit alone and bits past the last counter read zero.
module perfmon_freeze_overflow_status
    import perfmon_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  ce_in,
    // capability straps
    input  wire logic                  monitoring_supported_flag_in,
    input  wire logic                  ext_irq_mode_in,
    // register port
    input  wire bus_req_type           bus_in,
    output logic [`DATA_W-1:0]         rdata_out,
    // counter side
    input  wire counter_vec_type       overflow_in,
    // command interface side
    input  wire counter_vec_type       freeze_in,
    input  wire counter_vec_type       unfreeze_in,
    input  wire logic                  disable_done_in,
    input  wire logic [`CNT_IDX_W-1:0] disable_index_in,
    // state towards the monitoring unit
    output counter_vec_type            freeze_state_out,
    output logic [`DATA_W-1:0]         upper_message_address_out,
    output logic                       irq_out
);

    localparam int NC   = `NUM_COUNTERS;
    localparam int PADW = `NUM_WORDS * 32;

    // true when the address falls on a word of a status block
    function automatic logic in_block(
        input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] base
    );
        logic [`ADDR_W-1:0] span;
        span = `ADDR_W'(`NUM_WORDS * 4);
        return (a >= base) && (a < base + span) && (a[1:0] == 2'b00);
    endfunction : in_block

    // word number inside a status block
    function automatic int word_of(
        input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] base
    );
        logic [`ADDR_W-1:0] off;
        off = a - base;
        return int'(off[`ADDR_W-1:2]);
    endfunction : word_of

    // one word of a status vector, bits past the last counter as zero
    function automatic logic [31:0] pick_word(
        input counter_vec_type    v,
        input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] base
    );
        padded_vec_type p;
        p = PADW'(v);
        return p[word_of(a, base)*32 +: 32];
    endfunction : pick_word

    // counters whose bit sits at a one in the written word
    function automatic counter_vec_type one_mask(
        input logic [31:0]        d,
        input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] base
    );
        counter_vec_type m;
        m = '0;
        for (int i = 0; i < NC; i++) begin
            m[i] = (word_of(a, base) == i / 32) && d[i % 32];
        end
        return m;
    endfunction : one_mask

    // state
    logic [`DATA_W-1:0] upper_message_address;
    counter_vec_type    freeze_state_bits;
    counter_vec_type    overflow_flag_bits;
    event_vec_type      irq_status;
    event_vec_type      irq_mask;

    logic [`DATA_W-1:0] next_upper_message_address;
    counter_vec_type    next_freeze_state_bits;
    counter_vec_type    next_overflow_flag_bits;
    event_vec_type      next_irq_status;
    event_vec_type      next_irq_mask;
    logic [`DATA_W-1:0] next_rdata;
    logic               next_irq;

    // decode
    logic monitoring_supported_flag;
    logic upper_impl;
    logic wr_upper;
    logic wr_ovf;
    logic wr_sts;
    logic wr_mask;
    logic rd_frz;
    logic rd_ovf;

    always_comb begin
        monitoring_supported_flag        = monitoring_supported_flag_in;
        upper_impl = monitoring_supported_flag && ext_irq_mode_in;                                   // [RULE1] [RULE2] [RULE3]
        wr_upper   = bus_in.wr && (bus_in.addr == `OFF_UPPER_ADDR);
        wr_ovf     = bus_in.wr && in_block(bus_in.addr, `OFF_OVERFLOW_BASE);   // [RULE9] [RULE12]
        wr_sts     = bus_in.wr && (bus_in.addr == `OFF_IRQ_STATUS);
        wr_mask    = bus_in.wr && (bus_in.addr == `OFF_IRQ_MASK);
        rd_frz     = in_block(bus_in.addr, `OFF_FREEZE_BASE);                  // [RULE4] [RULE12]
        rd_ovf     = in_block(bus_in.addr, `OFF_OVERFLOW_BASE);
    end

    // upper message address
    always_comb begin
        next_upper_message_address = upper_message_address;
        if (!upper_impl) begin
            next_upper_message_address = `RST_UPPER_ADDR;                      // [RULE2] [RULE3]
        end else if (wr_upper) begin
            next_upper_message_address = bus_in.wdata;                         // [RULE1]
        end
    end

    // freeze state: only command-interface inputs and the monitoring strap move it, the bus cannot
    counter_vec_type disable_vec;

    always_comb begin
        disable_vec = '0;
        if (disable_done_in) begin
            disable_vec = counter_vec_type'(1) << disable_index_in;            // [RULE8]
        end
        // a freeze arriving with a clear of the same counter wins
        next_freeze_state_bits = (freeze_state_bits & ~unfreeze_in & ~disable_vec)
                               | freeze_in;                                    // [RULE5] [RULE6] [RULE7]
        if (!monitoring_supported_flag) begin
            next_freeze_state_bits = '0;                                       // [RULE3]
        end
    end

    // overflow flags, write one to clear
    counter_vec_type ovf_clear;

    always_comb begin
        ovf_clear = '0;
        if (wr_ovf) begin
            ovf_clear = one_mask(bus_in.wdata, bus_in.addr, `OFF_OVERFLOW_BASE); // [RULE11] [RULE13]
        end
        // an overflow in the clearing cycle is kept
        next_overflow_flag_bits = (overflow_flag_bits & ~ovf_clear) | overflow_in; // [RULE10]
        if (!monitoring_supported_flag) begin
            next_overflow_flag_bits = '0;                                      // [RULE3]
        end
    end

    // interrupt status and mask
    event_vec_type events;

    always_comb begin
        events               = '0;
        events[`EV_OVERFLOW] = monitoring_supported_flag && (|(overflow_in & ~overflow_flag_bits));
        events[`EV_FREEZE]   = monitoring_supported_flag && (|(freeze_in & ~freeze_state_bits));
        next_irq_status      = irq_status;
        if (wr_sts) begin
            next_irq_status = irq_status & ~bus_in.wdata[`EV_W-1:0];
        end
        next_irq_status = next_irq_status | events;
        next_irq_mask   = irq_mask;
        if (wr_mask) begin
            next_irq_mask = bus_in.wdata[`EV_W-1:0];
        end
        // from next values so the pin follows the status in the same cycle
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // read data, zero for unmapped or absent words
    always_comb begin
        next_rdata = `RST_RDATA;
        if (bus_in.rd) begin
            if (bus_in.addr == `OFF_UPPER_ADDR) begin
                next_rdata = upper_impl ? upper_message_address : `RST_UPPER_ADDR; // [RULE2] [RULE3]
            end else if (rd_frz && monitoring_supported_flag) begin
                next_rdata = pick_word(freeze_state_bits, bus_in.addr, `OFF_FREEZE_BASE); // [RULE4] [RULE13]
            end else if (rd_ovf && monitoring_supported_flag) begin
                next_rdata = pick_word(overflow_flag_bits, bus_in.addr, `OFF_OVERFLOW_BASE); // [RULE9] [RULE13]
            end else if (bus_in.addr == `OFF_IRQ_STATUS) begin
                next_rdata = `DATA_W'(irq_status);
            end else if (bus_in.addr == `OFF_IRQ_MASK) begin
                next_rdata = `DATA_W'(irq_mask);
            end
        end
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            upper_message_address <= `RST_UPPER_ADDR;
            freeze_state_bits     <= '0;
            overflow_flag_bits    <= '0;
            irq_status            <= `RST_IRQ_STATUS;
            irq_mask              <= `RST_IRQ_MASK;
            rdata_out             <= `RST_RDATA;
            irq_out               <= 1'b0;
        end else if (ce_in) begin
            upper_message_address <= next_upper_message_address;
            freeze_state_bits     <= next_freeze_state_bits;
            overflow_flag_bits    <= next_overflow_flag_bits;
            irq_status            <= next_irq_status;
            irq_mask              <= next_irq_mask;
            rdata_out             <= next_rdata;
            irq_out               <= next_irq;
        end
    end

    // copies for the monitoring unit, kept as flops so outputs stay registered
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            freeze_state_out          <= '0;
            upper_message_address_out <= `RST_UPPER_ADDR;
        end else if (ce_in) begin
            freeze_state_out          <= next_freeze_state_bits;
            upper_message_address_out <= next_upper_message_address;
        end
    end

endmodule : perfmon_freeze_overflow_status

// File: rtl/perfmon_params.svh
// constants for the counter freeze and overflow status bank
`ifndef PERFMON_PARAMS_SVH
`define PERFMON_PARAMS_SVH

// counters served and index width
`define NUM_COUNTERS 16
`define CNT_IDX_W 4
// 64-bit status registers needed, and 32-bit words they span
`define NUM_REGS ((`NUM_COUNTERS + 63) / 64)
`define NUM_WORDS (`NUM_REGS * 2)

// register port widths
`define ADDR_W 12
`define DATA_W 32

// byte offsets
`define OFF_UPPER_ADDR 12'h334
`define OFF_FREEZE_BASE 12'h340
`define OFF_OVERFLOW_BASE 12'h360
`define OFF_IRQ_STATUS 12'h3F0
`define OFF_IRQ_MASK 12'h3F4

// interrupt status bit positions
`define EV_OVERFLOW 0
`define EV_FREEZE 1
`define EV_W 2

// reset values
`define RST_UPPER_ADDR 32'h0000_0000
`define RST_IRQ_STATUS 2'h0
`define RST_IRQ_MASK 2'h0
`define RST_RDATA 32'h0000_0000

`endif

// File: rtl/perfmon_pkg.sv
// types shared by the counter freeze and overflow status bank
`include "perfmon_params.svh"
package perfmon_pkg;

    // one register port request
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic               wr;
        logic               rd;
    } bus_req_type;

    typedef logic [`NUM_COUNTERS-1:0] counter_vec_type;
    typedef logic [`NUM_WORDS*32-1:0] padded_vec_type;
    typedef logic [`EV_W-1:0]         event_vec_type;

endpackage : perfmon_pkg

// File: tb/perfmon_status_asserts.sv
// concurrent checks on the freeze and overflow status bank ports
`timescale 1ns/1ps
`include "perfmon_params.svh"
module perfmon_status_checker
    import perfmon_pkg::*;
(
    // clock and controls
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire logic                  ce_in,
    input wire logic                  monitoring_supported_flag_in,
    input wire logic                  ext_irq_mode_in,
    // register port
    input wire bus_req_type           bus_in,
    input wire logic [`DATA_W-1:0]    rdata_out,
    // events and state
    input wire counter_vec_type       overflow_in,
    input wire counter_vec_type       freeze_in,
    input wire counter_vec_type       unfreeze_in,
    input wire logic                  disable_done_in,
    input wire logic [`CNT_IDX_W-1:0] disable_index_in,
    input wire counter_vec_type       freeze_state_out,
    input wire logic [`DATA_W-1:0]    upper_message_address_out,
    input wire logic                  irq_out
);
    logic run;
    assign run = ce_in && monitoring_supported_flag_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_ovf; run && overflow_in[0]; endsequence
    sequence s_ovf_rd; run && bus_in.rd && bus_in.addr == `OFF_OVERFLOW_BASE; endsequence
    property p_rd_idle; ce_in && !bus_in.rd |=> rdata_out == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_upper_wr;
        run && ext_irq_mode_in && bus_in.wr && bus_in.addr == `OFF_UPPER_ADDR
            |=> upper_message_address_out == $past(bus_in.wdata);
    endproperty
    a_upper_wr: assert property (p_upper_wr) else $error("upper address write lost");
    property p_upper_off; ce_in && !ext_irq_mode_in |=> upper_message_address_out == '0; endproperty
    a_upper_off: assert property (p_upper_off) else $error("upper address not zero");
    property p_absent;
        ce_in && !monitoring_supported_flag_in |=> freeze_state_out == '0 && upper_message_address_out == '0;
    endproperty
    a_absent: assert property (p_absent) else $error("state kept without monitoring");
    property p_frz_rd;
        ce_in && bus_in.rd && bus_in.addr == `OFF_FREEZE_BASE |=> rdata_out == 32'($past(freeze_state_out));
    endproperty
    a_frz_rd: assert property (p_frz_rd) else $error("freeze readback wrong");
    property p_frz_hold;
        run && freeze_in == '0 && unfreeze_in == '0 && !disable_done_in |=> $stable(freeze_state_out);
    endproperty
    a_frz_hold: assert property (p_frz_hold) else $error("freeze bits moved without command");
    property p_frz_set; run && freeze_in != '0 |=> (freeze_state_out & $past(freeze_in)) == $past(freeze_in);
    endproperty
    a_frz_set: assert property (p_frz_set) else $error("freeze command not taken");
    property p_dis_clr;
        run && disable_done_in && freeze_in == '0 |=> !freeze_state_out[$past(disable_index_in)];
    endproperty
    a_dis_clr: assert property (p_dis_clr) else $error("disable left counter frozen");
    property p_ovf_seen; s_ovf ##1 s_ovf_rd |=> rdata_out[0]; endproperty
    a_ovf_seen: assert property (p_ovf_seen) else $error("overflow not reported");
endmodule : perfmon_status_checker

bind perfmon_freeze_overflow_status perfmon_status_checker i_chk (.clk_in, .rst_in, .ce_in,
    .monitoring_supported_flag_in, .ext_irq_mode_in, .bus_in, .rdata_out, .overflow_in, .freeze_in,
    .unfreeze_in, .disable_done_in, .disable_index_in, .freeze_state_out, .upper_message_address_out, .irq_out);

// File: tb/perfmon_freeze_overflow_status_tb.sv
// self-checking bench for the freeze and overflow status bank
`timescale 1ns/1ps
`include "perfmon_params.svh"
module perfmon_freeze_overflow_status_tb;
    import perfmon_pkg::*;
    logic                  clk_in = 1'b0;
    logic                  rst_in = 1'b1;
    logic                  ce_in  = 1'b1;
    logic                  monitoring_supported_flag    = 1'b1;
    logic                  ext    = 1'b1;
    logic                  dis    = 1'b0;
    logic [`CNT_IDX_W-1:0] idx    = '0;
    bus_req_type           bus    = '0;
    counter_vec_type       ovf    = '0, frz = '0, unf = '0, fso;
    logic [`DATA_W-1:0]    rdata, upper;
    logic                  irq;
    int                    num_errors = 0, n_checks = 0;

    always #20 clk_in = ~clk_in;

    perfmon_freeze_overflow_status i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .monitoring_supported_flag_in(monitoring_supported_flag), .ext_irq_mode_in(ext), .bus_in(bus), .rdata_out(rdata),
        .overflow_in(ovf), .freeze_in(frz), .unfreeze_in(unf), .disable_done_in(dis),
        .disable_index_in(idx), .freeze_state_out(fso), .upper_message_address_out(upper), .irq_out(irq));

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in) bus.wr <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample there
    task rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_in) bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in) bus.rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask : rchk
    task ev(input counter_vec_type o, input counter_vec_type f, input counter_vec_type u, input logic d,
            input logic [3:0] i);
        @(posedge clk_in) {ovf, frz, unf, dis, idx} <= {o, f, u, d, i};
        @(posedge clk_in) {ovf, frz, unf, dis} <= '0;
        #1;
    endtask : ev
    task t_reset;
        rchk("upper", `OFF_UPPER_ADDR, 32'h0);
        rchk("freeze", `OFF_FREEZE_BASE, 32'h0);
        rchk("overflow", `OFF_OVERFLOW_BASE, 32'h0);
    endtask : t_reset
    task t_upper;
        wr(`OFF_UPPER_ADDR, 32'hA5C3_0F96);
        rchk("upper", `OFF_UPPER_ADDR, 32'hA5C3_0F96);
        @(posedge clk_in) ext <= 1'b0;
        wr(`OFF_UPPER_ADDR, 32'h1234_5678);
        rchk("upper off", `OFF_UPPER_ADDR, 32'h0);
        @(posedge clk_in) ext <= 1'b1;
        rchk("upper held", `OFF_UPPER_ADDR, 32'h0);
    endtask : t_upper
    task t_freeze;
        ev('0, 16'h8009, '0, 1'b0, 4'h0);
        chk("freeze pin", 32'h8009, 32'(fso));
        wr(`OFF_FREEZE_BASE, 32'h0);
        rchk("freeze ro", `OFF_FREEZE_BASE, 32'h8009);
        ev('0, 16'h0008, 16'h8008, 1'b1, 4'h0);
        rchk("freeze cmd", `OFF_FREEZE_BASE, 32'h0008);
        rchk("freeze high", `OFF_FREEZE_BASE + 12'h4, 32'h0);
        ev('0, '0, '0, 1'b1, 4'h3);
        chk("freeze off", 32'h0, 32'(fso));
    endtask : t_freeze
    task t_overflow;
        wr(`OFF_IRQ_STATUS, 32'h3);
        wr(`OFF_IRQ_MASK, 32'h0);
        @(posedge clk_in) ovf <= 16'h8001;
        @(posedge clk_in) ovf <= '0;
        bus <= '{addr: `OFF_OVERFLOW_BASE, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in) bus.rd <= 1'b0;
        #1 chk("overflow set", 32'h8001, rdata);
        chk("irq masked", 32'h0, 32'(irq));
        wr(`OFF_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, 32'(irq));
        wr(`OFF_OVERFLOW_BASE, 32'h0);
        rchk("overflow w0", `OFF_OVERFLOW_BASE, 32'h8001);
        wr(`OFF_OVERFLOW_BASE, 32'h1);
        rchk("overflow w1c", `OFF_OVERFLOW_BASE, 32'h8000);
        rchk("overflow high", `OFF_OVERFLOW_BASE + 12'h4, 32'h0);
        rchk("unmapped", 12'h100, 32'h0);
        wr(`OFF_IRQ_STATUS, 32'h1);
        chk("irq clear", 32'h0, 32'(irq));
    endtask : t_overflow
    task t_absent;
        @(posedge clk_in) monitoring_supported_flag <= 1'b0;
        ev(16'h0001, 16'h0001, '0, 1'b0, 4'h0);
        chk("freeze absent", 32'h0, 32'(fso));
        rchk("overflow absent", `OFF_OVERFLOW_BASE, 32'h0);
        @(posedge clk_in) monitoring_supported_flag <= 1'b1;
        rchk("overflow back", `OFF_OVERFLOW_BASE, 32'h0);
    endtask : t_absent
    // clock enable low must swallow events, and a mid-run reset must restore the upper address
    task t_hold;
        @(posedge clk_in) ce_in <= 1'b0;
        ev(16'h0004, 16'h0004, '0, 1'b0, 4'h0);
        @(posedge clk_in) ce_in <= 1'b1;
        rchk("overflow gated", `OFF_OVERFLOW_BASE, 32'h0);
        chk("freeze gated", 32'h0, 32'(fso));
        wr(`OFF_UPPER_ADDR, 32'h0BAD_F00D);
        @(posedge clk_in) rst_in <= 1'b1;
        @(posedge clk_in) rst_in <= 1'b0;
        rchk("upper reset", `OFF_UPPER_ADDR, 32'h0);
    endtask : t_hold
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_upper();
        t_freeze();
        t_overflow();
        t_absent();
        t_hold();
        tally_and_finish();
    end
    // the tests need about eighty cycles, so this limit only trips on a hang
    initial begin
        repeat (3000) @(posedge clk_in);
        num_errors++;
        tally_and_finish();
    end
endmodule : perfmon_freeze_overflow_status_tb
